// *** bench/drive_model.sv ***
// Purpose: behavioural motor drive facing the converter
// Assumes: reacts one cycle after its run command
// Notes: status echoes the inverted control word
`timescale 1ns/1ps
module drive_model (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic run_fwd_i,
  input wire logic run_rev_i,
  input wire logic [15:0] ctrl_i,
  output logic running_fwd_o,
  output logic running_rev_o,
  output logic at_ref_o,
  output logic [15:0] status_o
);
  ////////////////////////////////////////////////////////////////////////
  // inverted echo so a stuck pass-through cannot look right
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {running_fwd_o, running_rev_o, at_ref_o} <= 3'h0;
      status_o <= 16'hffff;
    end else begin
      running_fwd_o <= run_fwd_i & ~run_rev_i;
      running_rev_o <= run_rev_i & ~run_fwd_i;
      at_ref_o <= run_fwd_i ^ run_rev_i;
      status_o <= ~ctrl_i;
    end
  end
endmodule : drive_model

// *** bench/drive_profile_reference_converter_assertions.sv ***
// Purpose: port-level checks on the converter
// Assumes: bound to the converter top
// Notes: flag latency is 3 edges, the 2-stage pin synchroniser plus the output register
`timescale 1ns/1ps
module drive_profile_reference_converter_assertions (
  input wire logic ref_clk_i, rst_b_i, net_run_source_req_i, net_ref_source_req_i,
  input wire logic net_run_fwd_i, local_run_fwd_i, drive_faulted_i, drive_run_fwd_o,
  input wire logic run_source_is_network_o, reference_source_is_network_o, ready_o, faulted_o,
  input wire logic [15:0] net_control_word_i, drive_control_word_o, fault_code_value_o,
  input wire logic [2:0] supervisor_state_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_ctrl_word_pass: assert property (
    $past(rst_b_i) |-> drive_control_word_o == $past(net_control_word_i)) else $error("ctrl word");
  a_run_select: assert property (
    $past(rst_b_i) |-> drive_run_fwd_o == ($past(net_run_source_req_i) ? $past(net_run_fwd_i)
      : $past(local_run_fwd_i))) else $error("run select");
  a_run_src_flag: assert property (
    $past(rst_b_i) |-> run_source_is_network_o == $past(net_run_source_req_i)) else $error("run src");
  a_ref_src_flag: assert property (
    $past(rst_b_i) |-> reference_source_is_network_o == $past(net_ref_source_req_i))
    else $error("ref src");
  a_ready_states: assert property (
    ready_o == (supervisor_state_o inside {3'h3, 3'h4, 3'h5})) else $error("ready state");
  a_fault_flag: assert property (
    $past(rst_b_i, 3) |-> faulted_o == $past(drive_faulted_i, 3)) else $error("fault flag");
  a_fault_code_idle: assert property (
    !faulted_o |-> fault_code_value_o == 16'h0000) else $error("fault code");
  a_state_code: assert property (
    supervisor_state_o != 3'h0) else $error("state code");
endmodule : drive_profile_reference_converter_assertions
bind drive_profile_reference_converter drive_profile_reference_converter_assertions u_chk (.*);

// *** bench/testbench.sv ***
// Purpose: directed checks of the converter
// Assumes: conversions settle within 600 cycles
// Notes: units are Q8.8, 16'h0100 is one unit
`timescale 1ns/1ps
module testbench;
  logic ref_clk_i = 0, rst_b_i = 0, scalar_mode_i = 1, net_run_source_req_i = 1;
  logic net_ref_source_req_i = 1, net_run_fwd_i = 0, net_run_rev_i = 0, local_run_fwd_i = 0;
  logic local_run_rev_i = 0, drive_faulted_i = 0, drive_warning_i = 0, drive_ready_i = 1;
  logic drive_running_fwd_i, drive_running_rev_i, drive_at_reference_i;
  logic [15:0] speed_unit_i = 16'h0100, torque_unit_i = 16'h0100, motor_nominal_frequency_i = 16'h003c;
  logic [15:0] motor_sync_speed_i = 16'h0708, motor_nominal_torque_i = 16'h03e8;
  logic [15:0] net_control_word_i = 16'h0000, drive_fault_code_i = 16'h0000;
  logic [15:0] drive_warning_code_i = 16'h0000, drive_status_word_i;
  logic signed [15:0] net_speed_reference_i = 16'h0384, net_torque_reference_i = 16'h01f4;
  logic signed [15:0] local_speed_reference_i = 16'h0000, local_torque_reference_i = 16'h0000;
  logic signed [15:0] drive_frequency_actual_i = 16'h001e, drive_speed_actual_i = 16'h01c2;
  logic signed [15:0] drive_torque_percent_actual_i = 16'h0032;
  logic drive_run_fwd_o, drive_run_rev_o, faulted_o, warning_o, running_fwd_o, running_rev_o;
  logic ready_o, run_source_is_network_o, reference_source_is_network_o, at_reference_o;
  logic [2:0] supervisor_state_o;
  logic [15:0] drive_control_word_o, net_status_word_o, fault_code_value_o, warning_code_value_o;
  logic signed [15:0] drive_frequency_reference_o, drive_speed_reference_o;
  logic signed [15:0] drive_torque_reference_o, net_speed_actual_o, net_torque_actual_o;
  int err_count = 0;
  int check_count = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  drive_profile_reference_converter u_dut (.*);
  drive_model u_drive (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .run_fwd_i(drive_run_fwd_o),
    .run_rev_i(drive_run_rev_o), .ctrl_i(drive_control_word_o), .running_fwd_o(drive_running_fwd_i),
    .running_rev_o(drive_running_rev_i), .at_ref_o(drive_at_reference_i),
    .status_o(drive_status_word_i));
  ////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // bounded wait on the state code; running out ends the run
  task wait_state(input logic [2:0] s);
    int i;
    for (i = 0; i < 400 && supervisor_state_o !== s; i++) @(posedge ref_clk_i);
    if (i == 400) begin
      err_count++;
      stop_test();
    end
  endtask : wait_state
  task t_state;
    wait_state(3'h3);
    chk("ready", 16'h0001, ready_o);
    @(posedge ref_clk_i) net_run_fwd_i <= 1;
    wait_state(3'h4);
    repeat (4) @(posedge ref_clk_i);
    chk("run fwd", 16'h0001, running_fwd_o);
    chk("at ref", 16'h0001, at_reference_o);
    @(posedge ref_clk_i) net_run_fwd_i <= 0;
    wait_state(3'h3);
  endtask : t_state
  task t_conv;
    repeat (600) @(posedge ref_clk_i);
    chk("freq ref", 16'h001e, drive_frequency_reference_o);
    chk("torque ref", 16'h0032, drive_torque_reference_o);
    chk("speed act", 16'h0384, net_speed_actual_o);
    chk("torque act", 16'h01f4, net_torque_actual_o);
    @(posedge ref_clk_i) {scalar_mode_i, speed_unit_i} <= {1'b0, 16'h0080};
    repeat (600) @(posedge ref_clk_i);
    chk("speed ref", 16'h01c2, drive_speed_reference_o);
    chk("vec act", 16'h0384, net_speed_actual_o);
    @(posedge ref_clk_i) {net_speed_reference_i, speed_unit_i} <= {16'h8ad0, 16'h0200};
    repeat (600) @(posedge ref_clk_i);
    chk("sat ref", 16'h8000, drive_speed_reference_o);
    chk("vec act", 16'h00e1, net_speed_actual_o);
  endtask : t_conv
  task t_source;
    @(posedge ref_clk_i) {net_run_source_req_i, net_ref_source_req_i, local_run_fwd_i} <= 3'h1;
    {local_speed_reference_i, net_control_word_i} <= {16'h0123, 16'h0a5f};
    repeat (4) @(posedge ref_clk_i);
    chk("local run", 16'h0001, drive_run_fwd_o);
    chk("run src", 16'h0000, run_source_is_network_o);
    chk("ref src", 16'h0000, reference_source_is_network_o);
    chk("local ref", 16'h0123, drive_frequency_reference_o);
    chk("status", 16'hf5a0, net_status_word_o);
    @(posedge ref_clk_i) {local_run_fwd_i, local_run_rev_i} <= 2'h1;
    repeat (6) @(posedge ref_clk_i);
    chk("run rev", 16'h0001, running_rev_o);
    @(posedge ref_clk_i) local_run_rev_i <= 0;
    wait_state(3'h3);
  endtask : t_source
  task t_fault;
    @(posedge ref_clk_i) {drive_warning_i, drive_warning_code_i} <= {1'b1, 16'h0042};
    repeat (5) @(posedge ref_clk_i);
    chk("warn code", 16'h0042, warning_code_value_o);
    chk("warn", 16'h0001, warning_o);
    @(posedge ref_clk_i) {drive_faulted_i, drive_fault_code_i} <= {1'b1, 16'h00e1};
    wait_state(3'h7);
    chk("fault code", 16'h00e1, fault_code_value_o);
    chk("not ready", 16'h0000, ready_o);
    @(posedge ref_clk_i) drive_faulted_i <= 0;
    wait_state(3'h3);
  endtask : t_fault
  initial begin
    repeat (16) @(posedge ref_clk_i);
    chk("startup", 16'h0001, supervisor_state_o);
    rst_b_i <= 1;
    t_state();
    t_conv();
    t_source();
    t_fault();
    stop_test();
  end
endmodule : testbench

// *** hw/drive_profile_reference_converter.sv ***
// Purpose: network drive-profile conversion between a network client and a motor drive
// Assumes: word-wide drive ports are synchronous to ref_clk_i; discrete drive pins are not
// Notes: conversions share one serial divider and refresh in a fixed round of four
//
// Summary of operation
// - run source request: 0 local, 1 network
// - reference source request: 0 local, 1 network
// - scalar: frequency = ref*unit*nominal freq / sync speed
// - vector: speed reference = ref times speed unit
// - torque percent = 100*ref*unit / nominal torque
// - faulted flag with readable fault code
// - warning flag with readable warning code
// - running forward indication
// - running reverse indication
// - ready in ready, enabled or stopping
// - report run source: 0 local, 1 network
// - report reference source: 0 local, 1 network
// - at-reference indication while at commanded value
// - report supervisor state as 3-bit code
// - scalar: speed actual = freq*sync/(nominal freq*unit)
// - vector: speed actual = drive speed / unit
// - torque actual = percent*nominal torque/(100*unit)
// - control word down, status word back through
`timescale 1ns/1ps
module drive_profile_reference_converter (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // configuration
  input wire logic scalar_mode_i,
  input wire logic [15:0] speed_unit_i,
  input wire logic [15:0] torque_unit_i,
  input wire logic [15:0] motor_nominal_frequency_i,
  input wire logic [15:0] motor_sync_speed_i,
  input wire logic [15:0] motor_nominal_torque_i,
  // network side
  input wire logic net_run_source_req_i,
  input wire logic net_ref_source_req_i,
  input wire logic net_run_fwd_i,
  input wire logic net_run_rev_i,
  input wire logic signed [15:0] net_speed_reference_i,
  input wire logic signed [15:0] net_torque_reference_i,
  input wire logic [15:0] net_control_word_i,
  // local control
  input wire logic local_run_fwd_i,
  input wire logic local_run_rev_i,
  input wire logic signed [15:0] local_speed_reference_i,
  input wire logic signed [15:0] local_torque_reference_i,
  // drive discrete pins
  input wire logic drive_faulted_i,
  input wire logic drive_warning_i,
  input wire logic drive_running_fwd_i,
  input wire logic drive_running_rev_i,
  input wire logic drive_at_reference_i,
  input wire logic drive_ready_i,
  // drive words
  input wire logic [15:0] drive_fault_code_i,
  input wire logic [15:0] drive_warning_code_i,
  input wire logic signed [15:0] drive_frequency_actual_i,
  input wire logic signed [15:0] drive_speed_actual_i,
  input wire logic signed [15:0] drive_torque_percent_actual_i,
  input wire logic [15:0] drive_status_word_i,
  // toward the drive
  output logic drive_run_fwd_o,
  output logic drive_run_rev_o,
  output logic signed [15:0] drive_frequency_reference_o,
  output logic signed [15:0] drive_speed_reference_o,
  output logic signed [15:0] drive_torque_reference_o,
  output logic [15:0] drive_control_word_o,
  // toward the network
  output logic [15:0] net_status_word_o,
  output logic signed [15:0] net_speed_actual_o,
  output logic signed [15:0] net_torque_actual_o,
  output logic faulted_o,
  output logic [15:0] fault_code_value_o,
  output logic warning_o,
  output logic [15:0] warning_code_value_o,
  output logic running_fwd_o,
  output logic running_rev_o,
  output logic ready_o,
  output logic run_source_is_network_o,
  output logic reference_source_is_network_o,
  output logic at_reference_o,
  output logic [2:0] supervisor_state_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [15:0] magnitude(input logic signed [15:0] v);
    magnitude = v[15] ? 16'(-v) : v;
  endfunction : magnitude

  // clamp an unsigned quotient with its sign into a signed word
  function automatic logic [15:0] saturate(input logic neg, input logic [63:0] q);
    if (neg) begin
      saturate = (q > 64'h0000_0000_0000_8000) ? drive_profile_pkg::WORD_NEG_MIN : 16'(-q[15:0]);
    end else begin
      saturate = (q > 64'h0000_0000_0000_7fff) ? drive_profile_pkg::WORD_POS_MAX : q[15:0];
    end
  endfunction : saturate

  ////////////////////////////////////////////////////////////////////////////////
  // discrete pins from the drive

  logic [5:0] pins_s;

  level_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({drive_ready_i, drive_at_reference_i, drive_running_rev_i,
              drive_running_fwd_i, drive_warning_i, drive_faulted_i}),
    .sync_o(pins_s)
  );

  wire fault_s = pins_s[0];
  wire warn_s = pins_s[1];
  wire fwd_s = pins_s[2];
  wire rev_s = pins_s[3];
  wire at_ref_s = pins_s[4];
  wire rdy_s = pins_s[5];
  wire running_s = fwd_s | rev_s;

  ////////////////////////////////////////////////////////////////////////////////
  // conversion operands

  drive_profile_pkg::conv_op_e op_r;
  logic launch_r;
  logic neg_r;
  logic div_busy;
  logic div_done;
  logic [63:0] div_quot;

  wire [15:0] osr_mag = magnitude(net_speed_reference_i);
  wire [15:0] otr_mag = magnitude(net_torque_reference_i);
  wire [15:0] dfa_mag = magnitude(drive_frequency_actual_i);
  wire [15:0] dsa_mag = magnitude(drive_speed_actual_i);
  wire [15:0] dta_mag = magnitude(drive_torque_percent_actual_i);

  wire [31:0] sr_us = osr_mag * speed_unit_i;
  wire [47:0] sr_us_mf = sr_us * motor_nominal_frequency_i;
  wire [31:0] tr_ut = otr_mag * torque_unit_i;
  wire [38:0] tr_ut_pct = tr_ut * drive_profile_pkg::PERCENT_FULL;
  wire [31:0] fa_mss = dfa_mag * motor_sync_speed_i;
  wire [31:0] mf_us = motor_nominal_frequency_i * speed_unit_i;
  wire [31:0] ta_mt = dta_mag * motor_nominal_torque_i;
  wire [22:0] ut_pct = torque_unit_i * drive_profile_pkg::PERCENT_FULL;

  // units are Q8.8: each unit term is balanced
  // by an 8-bit shift on the other side
  wire [63:0] num_sref_scalar = {16'h0000, sr_us_mf};
  wire [31:0] den_sref_scalar = {8'h00, motor_sync_speed_i, drive_profile_pkg::UNIT_FRAC_ZERO};
  wire [63:0] num_sref_vector = {32'h0000_0000, sr_us};
  wire [63:0] num_tref = {25'h000_0000, tr_ut_pct};
  wire [31:0] den_tref = {8'h00, motor_nominal_torque_i, drive_profile_pkg::UNIT_FRAC_ZERO};
  wire [63:0] num_sact_scalar = {24'h00_0000, fa_mss, drive_profile_pkg::UNIT_FRAC_ZERO};
  wire [63:0] num_sact_vector = {40'h00_0000_0000, dsa_mag, drive_profile_pkg::UNIT_FRAC_ZERO};
  wire [31:0] den_sact_vector = {16'h0000, speed_unit_i};
  wire [63:0] num_tact = {24'h00_0000, ta_mt, drive_profile_pkg::UNIT_FRAC_ZERO};
  wire [31:0] den_tact = {9'h000, ut_pct};

  wire is_sref = op_r == drive_profile_pkg::OP_SPEED_REF;
  wire is_tref = op_r == drive_profile_pkg::OP_TORQUE_REF;
  wire is_sact = op_r == drive_profile_pkg::OP_SPEED_ACT;

  wire [63:0] sref_num = scalar_mode_i ? num_sref_scalar : num_sref_vector;
  wire [31:0] sref_den = scalar_mode_i ? den_sref_scalar : drive_profile_pkg::UNIT_ONE_DEN;
  wire [63:0] sact_num = scalar_mode_i ? num_sact_scalar : num_sact_vector;
  wire [31:0] sact_den = scalar_mode_i ? mf_us : den_sact_vector;

  wire [63:0] op_num = is_sref ? sref_num : is_tref ? num_tref : is_sact ? sact_num : num_tact;
  wire [31:0] op_den = is_sref ? sref_den : is_tref ? den_tref : is_sact ? sact_den : den_tact;
  wire op_neg = is_sref ? net_speed_reference_i[15] :
                is_tref ? net_torque_reference_i[15] :
                is_sact ? (scalar_mode_i ? drive_frequency_actual_i[15] :
                           drive_speed_actual_i[15]) :
                drive_torque_percent_actual_i[15];

  wire [15:0] op_result = saturate(neg_r, div_quot);

  serial_divider u_divider (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(launch_r),
    .num_i(op_num),
    .den_i(op_den),
    .busy_o(div_busy),
    .done_o(div_done),
    .quot_o(div_quot)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // conversion sequencer: one divider, four results in rotation

  logic signed [15:0] conv_freq_ref_r;
  logic signed [15:0] conv_speed_ref_r;
  logic signed [15:0] conv_torque_ref_r;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_r <= drive_profile_pkg::OP_SPEED_REF;
      launch_r <= 1'b1;
      neg_r <= 1'b0;
    end else begin
      if (launch_r && !div_busy) begin
        launch_r <= 1'b0;
        neg_r <= op_neg;
      end else if (div_done) begin
        launch_r <= 1'b1;
        unique case (op_r)
          drive_profile_pkg::OP_SPEED_REF: op_r <= drive_profile_pkg::OP_TORQUE_REF;
          drive_profile_pkg::OP_TORQUE_REF: op_r <= drive_profile_pkg::OP_SPEED_ACT;
          drive_profile_pkg::OP_SPEED_ACT: op_r <= drive_profile_pkg::OP_TORQUE_ACT;
          drive_profile_pkg::OP_TORQUE_ACT: op_r <= drive_profile_pkg::OP_SPEED_REF;
          default: op_r <= drive_profile_pkg::OP_SPEED_REF;
        endcase
      end
    end
  end

  // a mode change lands on the next pass of that operation
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_freq_ref_r <= drive_profile_pkg::WORD_RST;
      conv_speed_ref_r <= drive_profile_pkg::WORD_RST;
      conv_torque_ref_r <= drive_profile_pkg::WORD_RST;
      net_speed_actual_o <= drive_profile_pkg::WORD_RST;
      net_torque_actual_o <= drive_profile_pkg::WORD_RST;
    end else if (div_done) begin
      if (is_sref && scalar_mode_i) conv_freq_ref_r <= op_result;
      if (is_sref && !scalar_mode_i) conv_speed_ref_r <= op_result;
      if (is_tref) conv_torque_ref_r <= op_result;
      if (is_sact) net_speed_actual_o <= op_result;
      if (op_r == drive_profile_pkg::OP_TORQUE_ACT) net_torque_actual_o <= op_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // source selection and words toward the drive

  wire run_net = net_run_source_req_i;
  wire ref_net = net_ref_source_req_i;
  wire sel_fwd = run_net ? net_run_fwd_i : local_run_fwd_i;
  wire sel_rev = run_net ? net_run_rev_i : local_run_rev_i;
  wire signed [15:0] sel_freq = ref_net ? conv_freq_ref_r : local_speed_reference_i;
  wire signed [15:0] sel_speed = ref_net ? conv_speed_ref_r : local_speed_reference_i;
  wire signed [15:0] sel_torque = ref_net ? conv_torque_ref_r : local_torque_reference_i;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drive_run_fwd_o <= 1'b0;
      drive_run_rev_o <= 1'b0;
      drive_frequency_reference_o <= drive_profile_pkg::WORD_RST;
      drive_speed_reference_o <= drive_profile_pkg::WORD_RST;
      drive_torque_reference_o <= drive_profile_pkg::WORD_RST;
      drive_control_word_o <= drive_profile_pkg::WORD_RST;
      net_status_word_o <= drive_profile_pkg::WORD_RST;
      run_source_is_network_o <= 1'b0;
      reference_source_is_network_o <= 1'b0;
    end else begin
      drive_run_fwd_o <= sel_fwd;
      drive_run_rev_o <= sel_rev;
      drive_frequency_reference_o <= sel_freq;
      drive_speed_reference_o <= sel_speed;
      drive_torque_reference_o <= sel_torque;
      drive_control_word_o <= net_control_word_i;
      net_status_word_o <= drive_status_word_i;
      run_source_is_network_o <= run_net;
      reference_source_is_network_o <= ref_net;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status flags toward the network

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      faulted_o <= 1'b0;
      fault_code_value_o <= drive_profile_pkg::WORD_RST;
      warning_o <= 1'b0;
      warning_code_value_o <= drive_profile_pkg::WORD_RST;
      running_fwd_o <= 1'b0;
      running_rev_o <= 1'b0;
      at_reference_o <= 1'b0;
    end else begin
      faulted_o <= fault_s;
      // codes read zero while unflagged, so stale codes never show
      fault_code_value_o <= fault_s ? drive_fault_code_i : drive_profile_pkg::WORD_RST;
      warning_o <= warn_s;
      warning_code_value_o <= warn_s ? drive_warning_code_i : drive_profile_pkg::WORD_RST;
      running_fwd_o <= fwd_s;
      running_rev_o <= rev_s;
      at_reference_o <= at_ref_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // supervisor state machine

  drive_profile_pkg::sup_state_e sup_r;
  drive_profile_pkg::sup_state_e sup_nxt;
  logic [7:0] startup_cnt_r;

  wire run_cmd = drive_run_fwd_o | drive_run_rev_o;
  wire startup_over = startup_cnt_r == drive_profile_pkg::STARTUP_LAST;

  always_comb begin
    sup_nxt = sup_r;
    unique case (sup_r)
      drive_profile_pkg::SUP_STARTUP: if (startup_over) sup_nxt = drive_profile_pkg::SUP_NOT_READY;
      drive_profile_pkg::SUP_NOT_READY: begin
        if (fault_s) sup_nxt = drive_profile_pkg::SUP_FAULTED;
        else if (rdy_s) sup_nxt = drive_profile_pkg::SUP_READY;
      end
      drive_profile_pkg::SUP_READY: begin
        if (fault_s) sup_nxt = drive_profile_pkg::SUP_FAULTED;
        else if (!rdy_s) sup_nxt = drive_profile_pkg::SUP_NOT_READY;
        else if (running_s) sup_nxt = drive_profile_pkg::SUP_ENABLED;
      end
      drive_profile_pkg::SUP_ENABLED: begin
        if (fault_s) sup_nxt = drive_profile_pkg::SUP_FAULT_STOP;
        else if (!run_cmd) sup_nxt = drive_profile_pkg::SUP_STOPPING;
      end
      drive_profile_pkg::SUP_STOPPING: begin
        if (fault_s) sup_nxt = drive_profile_pkg::SUP_FAULT_STOP;
        else if (run_cmd) sup_nxt = drive_profile_pkg::SUP_ENABLED;
        else if (!running_s) sup_nxt = drive_profile_pkg::SUP_READY;
      end
      drive_profile_pkg::SUP_FAULT_STOP: if (!running_s) sup_nxt = drive_profile_pkg::SUP_FAULTED;
      drive_profile_pkg::SUP_FAULTED: if (!fault_s) sup_nxt = drive_profile_pkg::SUP_NOT_READY;
      default: sup_nxt = drive_profile_pkg::SUP_STARTUP;
    endcase
  end

  wire [2:0] state_code =
    (sup_nxt == drive_profile_pkg::SUP_STARTUP) ? drive_profile_pkg::STATE_STARTUP :
    (sup_nxt == drive_profile_pkg::SUP_NOT_READY) ? drive_profile_pkg::STATE_NOT_READY :
    (sup_nxt == drive_profile_pkg::SUP_READY) ? drive_profile_pkg::STATE_READY :
    (sup_nxt == drive_profile_pkg::SUP_ENABLED) ? drive_profile_pkg::STATE_ENABLED :
    (sup_nxt == drive_profile_pkg::SUP_STOPPING) ? drive_profile_pkg::STATE_STOPPING :
    (sup_nxt == drive_profile_pkg::SUP_FAULT_STOP) ? drive_profile_pkg::STATE_FAULT_STOP :
    (sup_nxt == drive_profile_pkg::SUP_FAULTED) ? drive_profile_pkg::STATE_FAULTED :
    drive_profile_pkg::STATE_VENDOR;
  wire ready_nxt = (sup_nxt == drive_profile_pkg::SUP_READY) ||
                   (sup_nxt == drive_profile_pkg::SUP_ENABLED) ||
                   (sup_nxt == drive_profile_pkg::SUP_STOPPING);

  // registered from sup_nxt so they track sup_r exactly
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sup_r <= drive_profile_pkg::SUP_STARTUP;
      startup_cnt_r <= '0;
      supervisor_state_o <= drive_profile_pkg::STATE_CODE_RST;
      ready_o <= 1'b0;
    end else begin
      sup_r <= sup_nxt;
      if (!startup_over) startup_cnt_r <= startup_cnt_r + 1'b1;
      supervisor_state_o <= state_code;
      ready_o <= ready_nxt;
    end
  end

endmodule : drive_profile_reference_converter

// *** hw/level_sync.sv ***
// Purpose: two-stage synchroniser for discrete drive status pins
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 6
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule : level_sync

// *** hw/serial_divider.sv ***
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: start_i only while busy_o is low
// Notes: a zero divisor yields an all-ones quotient, which later saturates
`timescale 1ns/1ps
module serial_divider (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [drive_profile_pkg::NUM_W-1:0] num_i,
  input wire logic [drive_profile_pkg::DEN_W-1:0] den_i,
  output logic busy_o,
  output logic done_o,
  output logic [drive_profile_pkg::NUM_W-1:0] quot_o
);

  logic [drive_profile_pkg::DEN_W-1:0] rem_r;
  logic [drive_profile_pkg::DEN_W-1:0] den_r;
  logic [drive_profile_pkg::CNT_W-1:0] step_r;
  wire [drive_profile_pkg::DEN_W:0] shifted = {rem_r, quot_o[drive_profile_pkg::NUM_W-1]};
  wire [drive_profile_pkg::DEN_W:0] den_ext = {1'b0, den_r};
  wire fits = shifted >= den_ext;
  wire [drive_profile_pkg::DEN_W:0] trial = shifted - den_ext;
  wire last_step = step_r == drive_profile_pkg::DIV_LAST_STEP;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rem_r <= '0;
      den_r <= '0;
      step_r <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      quot_o <= '0;
    end else begin
      done_o <= busy_o & last_step;
      if (start_i && !busy_o) begin
        rem_r <= '0;
        den_r <= den_i;
        quot_o <= num_i;
        step_r <= '0;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        rem_r <= fits ? trial[drive_profile_pkg::DEN_W-1:0] : shifted[drive_profile_pkg::DEN_W-1:0];
        quot_o <= {quot_o[drive_profile_pkg::NUM_W-2:0], fits};
        step_r <= step_r + 1'b1;
        busy_o <= !last_step;
      end
    end
  end

endmodule : serial_divider

// *** inc/drive_profile_pkg.sv ***
// Purpose: shared constants and types for the drive profile reference converter
// Assumes: 125 MHz single clock, 16-bit signed network and drive words
// Notes: unit inputs are unsigned fixed point with UNIT_FRAC_BITS fraction bits
package drive_profile_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int WORD_W = 16;
  localparam int NUM_W = 64;
  localparam int DEN_W = 32;
  localparam int CNT_W = 7;
  localparam int SYNC_STAGES = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // scaling constants
  localparam int UNIT_FRAC_BITS = 8;
  localparam logic [7:0] UNIT_FRAC_ZERO = 8'h00;
  localparam logic [31:0] UNIT_ONE_DEN = 32'h0000_0100;
  localparam logic [6:0] PERCENT_FULL = 7'h64;
  localparam logic [15:0] WORD_POS_MAX = 16'h7fff;
  localparam logic [15:0] WORD_NEG_MIN = 16'h8000;
  localparam logic [CNT_W-1:0] DIV_LAST_STEP = 7'h3f;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [2:0] STATE_CODE_RST = 3'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // supervisor state codes as reported to the network
  localparam logic [2:0] STATE_VENDOR = 3'h0;
  localparam logic [2:0] STATE_STARTUP = 3'h1;
  localparam logic [2:0] STATE_NOT_READY = 3'h2;
  localparam logic [2:0] STATE_READY = 3'h3;
  localparam logic [2:0] STATE_ENABLED = 3'h4;
  localparam logic [2:0] STATE_STOPPING = 3'h5;
  localparam logic [2:0] STATE_FAULT_STOP = 3'h6;
  localparam logic [2:0] STATE_FAULTED = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int STARTUP_TIME_NS = 1000;
  localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STARTUP_LAST = 8'(STARTUP_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // state machines
  typedef enum logic [6:0] {
    SUP_STARTUP    = 7'h01,
    SUP_NOT_READY  = 7'h02,
    SUP_READY      = 7'h04,
    SUP_ENABLED    = 7'h08,
    SUP_STOPPING   = 7'h10,
    SUP_FAULT_STOP = 7'h20,
    SUP_FAULTED    = 7'h40
  } sup_state_e;

  typedef enum logic [3:0] {
    OP_SPEED_REF  = 4'h1,
    OP_TORQUE_REF = 4'h2,
    OP_SPEED_ACT  = 4'h4,
    OP_TORQUE_ACT = 4'h8
  } conv_op_e;

endpackage : drive_profile_pkg
